/* acs_host_model.sv */
// Host model that issues latched commands to the sequencer
`timescale 1ns/1ps
module acs_host_model
  import acs_pkg::*;
(
  input  wire logic            mclk_i,
  output logic                 cmd_latch_o,
  output acs_pkg::acs_cmd_type cmd_o,
  output logic [7:0]           cmd_byte_o,
  output logic                 gen_call_o,
  output acs_pkg::acs_cfg_type cfg_o
);
  logic mode_q;

  initial begin
    cmd_latch_o = 1'b0;
    cmd_o       = CMD_NONE;
    cmd_byte_o  = 8'h00;
    gen_call_o  = 1'b0;
    cfg_o       = CFG_RST;
    mode_q      = 1'b0;
  end

  // Released command byte carries the inverse of its last value, not a stale copy
  task automatic issue(input acs_cmd_type c, input logic [7:0] b,
                       input logic gc, input int gap);
    repeat (gap) @(posedge mclk_i);
    @(posedge mclk_i);
    cmd_latch_o <= 1'b1;
    cmd_o       <= c;
    cmd_byte_o  <= b;
    gen_call_o  <= gc;
    @(posedge mclk_i);
    cmd_latch_o <= 1'b0;
    cmd_o       <= CMD_NONE;
    cmd_byte_o  <= ~b;
    gen_call_o  <= 1'b0;
    if (gc || (c == CMD_RESET && (b == RST_CODE_A || b == RST_CODE_B)))
      mode_q = 1'b0;
  endtask

  task automatic wr_cfg(input acs_cfg_type c, input int gap);
    repeat (gap) @(posedge mclk_i);
    @(posedge mclk_i);
    cfg_o <= c;
    issue(CMD_WR_CFG, 8'h00, 1'b0, 0);
    cfg_o <= acs_cfg_type'(~c);
    // A mode change is always followed by a launch
    if (c.conversion_mode_bit != mode_q)
      issue(CMD_LAUNCH, 8'h00, 1'b0, 0);
    mode_q = c.conversion_mode_bit;
  endtask

  // Host offset correction: average two shorted readings, subtract
  function automatic logic [23:0] avg_sub(input logic [23:0] raw,
                                          input logic [23:0] a,
                                          input logic [23:0] b);
    return 24'(raw - 24'((25'(a) + 25'(b)) >> 1));
  endfunction
endmodule

/* acs_osc_gen.sv */
// Fractional divider that makes oscillator ticks from the main clock
`timescale 1ns/1ps
module acs_osc_gen
  import acs_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic run_i,
  acs_tick_if.src   tick
);
  import acs_pkg::*;

  // Phase accumulator at twice the oscillator rate so half clocks exist
  localparam logic [16:0] STEP = 17'(2 * OSC_KHZ);
  localparam logic [16:0] WRAP = 17'(MCLK_KHZ);

  logic [16:0] acc_q, acc_d;
  logic        half_q, half_d;
  logic [1:0]  mod_q, mod_d;
  logic        hit;

  always_comb begin
    hit    = (acc_q + STEP) >= WRAP;
    acc_d  = run_i ? (hit ? acc_q + STEP - WRAP : acc_q + STEP) : '0;
    half_d = (run_i && hit) ? ~half_q : (run_i ? half_q : 1'b0);
    mod_d  = mod_q;
    if (!run_i) begin
      mod_d = '0;
    end else if (hit && half_q) begin
      mod_d = 2'(mod_q + 2'h1);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_q  <= '0;
      half_q <= 1'b0;
      mod_q  <= '0;
    end else begin
      acc_q  <= acc_d;
      half_q <= half_d;
      mod_q  <= mod_d;
    end
  end

  // Modulator runs at a quarter of the oscillator
  assign tick.half_tick = run_i && hit;
  assign tick.osc_tick  = run_i && hit && half_q;
  assign tick.mod_tick  = run_i && hit && half_q && (mod_q == 2'h3);

  a_mod_quarter: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    tick.mod_tick |-> tick.osc_tick)
    else $error("modulator tick without oscillator tick");
endmodule

/* acs_pkg.sv */
// Shared constants and types for the conversion sequencer
package acs_pkg;

  localparam int          RESULT_W       = 24;
  localparam int          CMD_W          = 3;
  localparam int          MUX_W          = 3;
  localparam int          RATE_W         = 2;

  // Oscillator rate in kHz and main clock rate in kHz
  localparam int          OSC_KHZ        = 1024;
  localparam int          MCLK_KHZ       = 50000;
  localparam int          MOD_DIV        = 4;

  // Conversion periods in oscillator clocks, per rate code 0..3
  localparam int          CONT_T0        = 51192;
  localparam int          CONT_T1        = 11532;
  localparam int          CONT_T2        = 3116;
  localparam int          CONT_T3        = 1036;
  localparam int          SS_T0          = 51213;
  localparam int          SS_T1          = 11557;
  localparam int          SS_T2          = 3141;
  localparam int          SS_T3          = 1061;
  // First continuous start delay, in half oscillator clocks (28.5 clocks)
  localparam int          START_HALF     = 57;

  // Reference settle time in ns and its cycle count (least time, rounded up)
  localparam int          REF_SETTLE_NS  = 25000;
  localparam int          MCLK_NS        = 20;
  localparam int          REF_SETTLE_CYC = (REF_SETTLE_NS + MCLK_NS - 1)
                                           / MCLK_NS;

  // Input selection codes
  localparam logic [2:0]  MUX_SE_LO      = 3'h3;
  localparam logic [2:0]  MUX_SE_HI      = 3'h6;
  localparam logic [2:0]  MUX_SHORT      = 3'h7;

  // Configuration reset values
  localparam logic [2:0]  MUX_RST        = 3'h0;
  localparam logic        GAIN_RST       = 1'b0;
  localparam logic [1:0]  RATE_RST       = 2'h0;
  localparam logic        MODE_RST       = 1'b0;
  localparam logic        VREF_RST       = 1'b0;

  typedef enum logic [2:0] {
    CMD_NONE     = 3'h0,
    CMD_RESET    = 3'h1,
    CMD_LAUNCH   = 3'h2,
    CMD_SLEEP    = 3'h3,
    CMD_READ     = 3'h4,
    CMD_RD_CFG   = 3'h5,
    CMD_WR_CFG   = 3'h6
  } acs_cmd_type;

  // Reset command byte codes (general call reset needs no code)
  localparam logic [7:0]  RST_CODE_A     = 8'h06;
  localparam logic [7:0]  RST_CODE_B     = 8'h07;

  typedef struct packed {
    logic [2:0] input_select;
    logic       gain4;
    logic [1:0] rate;
    logic       conversion_mode_bit;
    logic       vref_ext;
  } acs_cfg_type;

  localparam acs_cfg_type CFG_RST = '{MUX_RST, GAIN_RST, RATE_RST,
                                      MODE_RST, VREF_RST};

endpackage

/* acs_result_buf.sv */
// Output result buffer with ready flag
`timescale 1ns/1ps
module acs_result_buf
  import acs_pkg::*;
#(
  parameter int WIDTH = RESULT_W
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_n_i,
  input  wire logic             clr_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] data_i,
  input  wire logic             read_i,
  input  wire logic             pend_i,
  output logic      [WIDTH-1:0] data_o,
  output logic                  ready_n_o
);
  import acs_pkg::*;

  if (WIDTH != RESULT_W) begin : g_chk
    $error("result width must match converter width");
  end

  logic [WIDTH-1:0] data_q, data_d;
  logic             rdy_n_q, rdy_n_d;

  always_comb begin
    data_d  = data_q;
    rdy_n_d = rdy_n_q;
    if (clr_i) begin
      data_d  = '0;
      rdy_n_d = 1'b1;
    end else if (load_i) begin
      // Load wins over read so a fresh result is never missed
      data_d  = data_i;
      rdy_n_d = 1'b0;
    end else if (read_i || pend_i) begin
      rdy_n_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_q  <= '0;
      rdy_n_q <= 1'b1;
    end else begin
      data_q  <= data_d;
      rdy_n_q <= rdy_n_d;
    end
  end

  assign data_o    = data_q;
  assign ready_n_o = rdy_n_q;

  a_buf_stable: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !load_i && !clr_i |=> $stable(data_o))
    else $error("result changed without a completed conversion");
  a_ready_fall: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    load_i && !clr_i |=> !ready_n_o)
    else $error("ready did not fall on new result");
endmodule

/* acs_sequencer.sv */
// Conversion sequencer: commands, modes, timing and result hand-off
`timescale 1ns/1ps
module acs_sequencer
  import acs_pkg::*;
(
  input  wire logic                        mclk_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        cmd_latch_i,
  input  wire acs_pkg::acs_cmd_type        cmd_i,
  input  wire logic [7:0]                  cmd_byte_i,
  input  wire logic                        gen_call_rst_i,
  input  wire acs_pkg::acs_cfg_type        cfg_wdata_i,
  input  wire logic [acs_pkg::RESULT_W-1:0] filt_data_i,
  output acs_pkg::acs_cfg_type             cfg_o,
  output logic [acs_pkg::MUX_W-1:0]        positive_input_o,
  output logic [acs_pkg::MUX_W-1:0]        negative_input_o,
  output logic                             neg_to_gnd_o,
  output logic                             short_mid_o,
  output logic [2:0]                       gain_o,
  output logic                             vref_ext_o,
  output logic                             ref_ready_o,
  output logic                             analog_on_o,
  output logic                             mod_clk_en_o,
  output logic                             filt_clear_o,
  output logic [acs_pkg::RESULT_W-1:0]     result_o,
  output logic                             result_ready_n_o,
  output logic                             busy_o
);
  import acs_pkg::*;

  typedef enum logic [1:0] {
    ST_SLEEP = 2'b00,
    ST_DELAY = 2'b01,
    ST_CONV  = 2'b11
  } acs_state_type;

  acs_state_type state_q, state_d;
  acs_cfg_type   cfg_q, cfg_d;
  logic [16:0]   cnt_q, cnt_d;   // counts half oscillator clocks
  logic          stop_q, stop_d;
  logic          single_q, single_d;
  logic [10:0]   ref_q, ref_d;
  logic          soft_rst, is_cmd, conv_done, load, pend, rd, restart;
  logic [16:0]   period_half, ss_half;
  acs_tick_if    tick ();

  // Reset command, either code, or general call all reset at once
  assign soft_rst = cmd_latch_i && ((cmd_i == CMD_RESET &&
                    (cmd_byte_i == RST_CODE_A || cmd_byte_i == RST_CODE_B))
                    || gen_call_rst_i);
  assign is_cmd   = cmd_latch_i && !soft_rst;

  acs_osc_gen u_osc (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .run_i   (state_q != ST_SLEEP),
    .tick    (tick)
  );

  // Per-rate lengths doubled to count in half clocks
  always_comb begin
    case (cfg_q.rate)
      2'h0:    period_half = 17'(2 * CONT_T0);
      2'h1:    period_half = 17'(2 * CONT_T1);
      2'h2:    period_half = 17'(2 * CONT_T2);
      default: period_half = 17'(2 * CONT_T3);
    endcase
    case (cfg_q.rate)
      2'h0:    ss_half = 17'(2 * SS_T0);
      2'h1:    ss_half = 17'(2 * SS_T1);
      2'h2:    ss_half = 17'(2 * SS_T2);
      default: ss_half = 17'(2 * SS_T3);
    endcase
  end

  assign restart   = is_cmd && (cmd_i == CMD_LAUNCH ||
                     (cmd_i == CMD_WR_CFG && state_q != ST_SLEEP));
  assign conv_done = state_q == ST_CONV && tick.half_tick &&
                     cnt_q == 17'h00001;
  assign load      = conv_done && !restart;
  assign rd        = is_cmd && cmd_i == CMD_READ;
  // Ready rises again when the next result is about to land
  assign pend      = state_q == ST_CONV && tick.half_tick &&
                     cnt_q == 17'h00005;

  always_comb begin
    state_d  = state_q;
    cfg_d    = cfg_q;
    cnt_d    = cnt_q;
    stop_d   = stop_q;
    single_d = single_q;
    if (is_cmd && cmd_i == CMD_WR_CFG) begin
      cfg_d = cfg_wdata_i;
    end
    if (is_cmd && cmd_i == CMD_SLEEP) begin
      stop_d = 1'b1;
    end
    if (tick.half_tick && cnt_q != '0) begin
      cnt_d = 17'(cnt_q - 17'h1);
    end
    if (restart) begin
      // Mode bit chooses how the launch proceeds
      single_d = !cfg_d.conversion_mode_bit;
      stop_d   = 1'b0;
      if (cfg_d.conversion_mode_bit) begin
        state_d = ST_DELAY;
        cnt_d   = 17'(START_HALF);
      end else begin
        state_d = ST_CONV;
        cnt_d   = ss_half;
      end
    end else begin
      case (state_q)
        ST_SLEEP: begin
          cnt_d = '0;
        end
        ST_DELAY: begin
          if (tick.half_tick && cnt_q == 17'h00001) begin
            state_d = ST_CONV;
            cnt_d   = period_half;
          end
        end
        ST_CONV: begin
          if (conv_done) begin
            if (single_q || stop_q) begin
              state_d = ST_SLEEP;
              stop_d  = 1'b0;
            end else begin
              cnt_d = period_half;
            end
          end
        end
        default: begin
          state_d = ST_SLEEP;
        end
      endcase
    end
  end

  // Reference settle counter restarts on wake or switch to internal
  always_comb begin
    ref_d = ref_q;
    if (state_q == ST_SLEEP || cfg_q.vref_ext) begin
      ref_d = '0;
    end else if (ref_q != 11'(REF_SETTLE_CYC)) begin
      ref_d = 11'(ref_q + 11'h1);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q  <= ST_SLEEP;
      cfg_q    <= CFG_RST;
      cnt_q    <= '0;
      stop_q   <= 1'b0;
      single_q <= 1'b0;
      ref_q    <= '0;
    end else if (soft_rst) begin
      state_q  <= ST_SLEEP;
      cfg_q    <= CFG_RST;
      cnt_q    <= '0;
      stop_q   <= 1'b0;
      single_q <= 1'b0;
      ref_q    <= '0;
    end else begin
      state_q  <= state_d;
      cfg_q    <= cfg_d;
      cnt_q    <= cnt_d;
      stop_q   <= stop_d;
      single_q <= single_d;
      ref_q    <= ref_d;
    end
  end

  // Single-ended inputs clamp negative codes to zero
  logic [RESULT_W-1:0] conv_val;
  assign conv_val = (neg_to_gnd_o && filt_data_i[RESULT_W-1]) ? '0
                    : filt_data_i;

  acs_result_buf #(.WIDTH(RESULT_W)) u_buf (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .clr_i     (soft_rst),
    .load_i    (load),
    .data_i    (conv_val),
    .read_i    (rd),
    .pend_i    (pend),
    .data_o    (result_o),
    .ready_n_o (result_ready_n_o)
  );

  // Input routing: 0..2 differential pairs, 3..6 single ended, 7 shorted
  always_comb begin
    positive_input_o = '0;
    negative_input_o = 3'h1;
    case (cfg_q.input_select)
      3'h0:    begin positive_input_o = 3'h0; negative_input_o = 3'h1; end
      3'h1:    begin positive_input_o = 3'h2; negative_input_o = 3'h3; end
      3'h2:    begin positive_input_o = 3'h1; negative_input_o = 3'h2; end
      3'h3:    positive_input_o = 3'h0;
      3'h4:    positive_input_o = 3'h1;
      3'h5:    positive_input_o = 3'h2;
      3'h6:    positive_input_o = 3'h3;
      default: begin positive_input_o = '0; negative_input_o = '0; end
    endcase
  end

  assign neg_to_gnd_o = cfg_q.input_select >= MUX_SE_LO &&
                        cfg_q.input_select <= MUX_SE_HI;
  // Offset is left to the host; no calibration logic here
  assign short_mid_o  = cfg_q.input_select == MUX_SHORT;
  assign gain_o       = cfg_q.gain4 ? 3'h4 : 3'h1;
  assign vref_ext_o   = cfg_q.vref_ext;
  assign ref_ready_o  = cfg_q.vref_ext || ref_q == 11'(REF_SETTLE_CYC);
  assign analog_on_o  = state_q != ST_SLEEP;
  assign mod_clk_en_o = state_q == ST_CONV && tick.mod_tick;
  assign filt_clear_o = restart || conv_done;
  assign cfg_o        = cfg_q;
  assign busy_o       = state_q != ST_SLEEP;

  a_reset_sleep: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    soft_rst |=> state_q == ST_SLEEP && cfg_q == CFG_RST)
    else $error("reset command did not return to sleep");
  a_single_end: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    conv_done && single_q && !restart && !soft_rst
    |=> state_q == ST_SLEEP)
    else $error("single-shot did not sleep after conversion");
  a_cont_reload: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    conv_done && !single_q && !stop_q && !restart && !soft_rst
    |=> state_q == ST_CONV && cnt_q == period_half)
    else $error("continuous conversion did not restart");
  a_launch_delay: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    restart && !soft_rst && cfg_d.conversion_mode_bit
    |=> state_q == ST_DELAY && cnt_q == 17'(START_HALF))
    else $error("continuous launch delay wrong");
  a_ss_latency: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    restart && !soft_rst && !cfg_d.conversion_mode_bit
    |=> state_q == ST_CONV && cnt_q == ss_half)
    else $error("single-shot latency wrong");
  a_sleep_waits: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    state_q == ST_CONV && !conv_done && !restart && !soft_rst
    |=> state_q == ST_CONV)
    else $error("conversion abandoned without reset");
  a_se_ground: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cfg_q.input_select == 3'h5 |-> neg_to_gnd_o && !short_mid_o)
    else $error("single-ended code did not ground negative input");
  a_se_positive: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    load && neg_to_gnd_o && !soft_rst |=> !result_o[RESULT_W-1])
    else $error("single-ended result negative");

  c_single: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    conv_done && single_q);
  c_cont: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    conv_done && !single_q && !stop_q);
  c_sleep: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    conv_done && stop_q);
  c_restart: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    restart && state_q == ST_CONV);
  c_delay: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    state_q == ST_DELAY && tick.half_tick && cnt_q == 17'h00001);

  // Output-side guards: these watch the front end controls, the filter clear, the ready flag and the sleep state,
  // so a slip in the decode shows up here before it reaches a result
  a_ref_sleep: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    state_q == ST_SLEEP |=> !ref_ready_o || cfg_q.vref_ext)
    else $error("internal reference ready straight after sleep");
  a_read_clears: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd && !load && !soft_rst |=> result_ready_n_o)
    else $error("ready stayed low after a read");
  a_gain_map: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    1'b1 |-> (gain_o == 3'h4) == cfg_q.gain4)
    else $error("gain does not follow the gain bit");
  a_short_mid: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cfg_q.input_select == MUX_SHORT |-> short_mid_o && !neg_to_gnd_o)
    else $error("shorted setting not applied");
  a_mod_gate: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    mod_clk_en_o |-> state_q == ST_CONV)
    else $error("modulator clocked outside a conversion");
  a_filt_clear: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    restart |-> filt_clear_o)
    else $error("filter not cleared on restart");
  // A write while asleep must only store, never wake the converter
  a_sleep_store: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    is_cmd && cmd_i == CMD_WR_CFG && state_q == ST_SLEEP
    |=> state_q == ST_SLEEP)
    else $error("configuration write woke the converter");
endmodule

/* acs_tick_if.sv */
// Oscillator and modulator tick bundle between sequencer modules
`timescale 1ns/1ps
interface acs_tick_if;
  logic osc_tick;
  logic half_tick;
  logic mod_tick;
  modport src (output osc_tick, output half_tick, output mod_tick);
  modport dst (input  osc_tick, input  half_tick, input  mod_tick);
endinterface

/* adc_conversion_sequencer_test.sv */
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  n_compared++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
  end \
end
module adc_conversion_sequencer_test;
  import acs_pkg::*;
  logic                mclk_i;
  logic                rst_n_i;
  logic                cmd_latch;
  acs_cmd_type         cmd;
  logic [7:0]          cmd_byte;
  logic                gen_call;
  acs_cfg_type         cfg_w;
  logic [RESULT_W-1:0] filt_q;
  acs_cfg_type         cfg_rd;
  logic [MUX_W-1:0]    pos_o;
  logic [MUX_W-1:0]    neg_o;
  logic                neg_gnd;
  logic                short_mid;
  logic [2:0]          gain;
  logic                vref_ext;
  logic                ref_ready;
  logic                analog_on;
  logic                mod_en;
  logic                filt_clr;
  logic [RESULT_W-1:0] result;
  logic                rdy_n;
  logic                busy;
  int                  miscompares;
  int                  n_compared;
  int                  cyc = 0;
  int                  t0;
  int                  n;
  acs_cfg_type         c;
  logic [RESULT_W-1:0] r1;

  acs_host_model u_host (
    .mclk_i      (mclk_i),
    .cmd_latch_o (cmd_latch),
    .cmd_o       (cmd),
    .cmd_byte_o  (cmd_byte),
    .gen_call_o  (gen_call),
    .cfg_o       (cfg_w)
  );

  acs_sequencer u_dut (
    .mclk_i           (mclk_i),
    .rst_n_i          (rst_n_i),
    .cmd_latch_i      (cmd_latch),
    .cmd_i            (cmd),
    .cmd_byte_i       (cmd_byte),
    .gen_call_rst_i   (gen_call),
    .cfg_wdata_i      (cfg_w),
    .filt_data_i      (filt_q),
    .cfg_o            (cfg_rd),
    .positive_input_o (pos_o),
    .negative_input_o (neg_o),
    .neg_to_gnd_o     (neg_gnd),
    .short_mid_o      (short_mid),
    .gain_o           (gain),
    .vref_ext_o       (vref_ext),
    .ref_ready_o      (ref_ready),
    .analog_on_o      (analog_on),
    .mod_clk_en_o     (mod_en),
    .filt_clear_o     (filt_clr),
    .result_o         (result),
    .result_ready_n_o (rdy_n),
    .busy_o           (busy)
  );

  function automatic logic [2:0] exp_pos(input logic [2:0] s);
    case (s)
      3'h0: return 3'h0;
      3'h1: return 3'h2;
      3'h2: return 3'h1;
      default: return s - 3'h3;
    endcase
  endfunction

  function automatic logic [2:0] exp_neg(input logic [2:0] s);
    return (s == 3'h0) ? 3'h1 : ((s == 3'h1) ? 3'h3 : 3'h2);
  endfunction

  // Latency window in clocks for a count of half oscillator periods;
  // the upper slack covers divider jitter and the registered flag
  function automatic logic in_win(input int lat, input int half);
    int e;
    e = half * MCLK_KHZ / (2 * OSC_KHZ);
    return (lat >= e - 2 && lat <= e + 6);
  endfunction

  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask

  task automatic wait_rdy(input logic lvl, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      if (rdy_n === lvl)
        break;
      tick(1);
    end
    if (i == lim) begin
      miscompares++;
      end_sim();
    end
  endtask

  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) cyc <= cyc + 1;

  initial begin
    rst_n_i     = 1'b0;
    filt_q      = '0;
    miscompares = 0;
    n_compared  = 0;
    void'($urandom(32'h7d36));
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    tick(1);
    `CHK(cfg_rd, CFG_RST)
    `CHK({rdy_n, busy, vref_ext}, 3'b100)
    // Every input code while asleep: the write only stores
    for (int k = 0; k < 8; k++) begin
      c = acs_cfg_type'(8'($urandom));
      c.input_select = 3'(k);
      c.conversion_mode_bit = 1'b0;
      u_host.wr_cfg(c, $urandom % 3);
      tick(2);
      `CHK(cfg_rd, c)
      `CHK(busy, 1'b0)
      `CHK(neg_gnd, (k >= 3 && k <= 6))
      `CHK(short_mid, (k == 7))
      `CHK(gain, (c.gain4 ? 3'h4 : 3'h1))
      `CHK(vref_ext, c.vref_ext)
      if (k < 7) `CHK(pos_o, exp_pos(3'(k)))
      if (k < 3) `CHK(neg_o, exp_neg(3'(k)))
    end
    u_host.issue(CMD_RESET, 8'h05, 1'b0, 0);
    tick(2);
    `CHK(cfg_rd, c)
    for (int i = 0; i < 3; i++) begin
      u_host.wr_cfg(acs_cfg_type'(8'hFC), 1);
      u_host.issue((i == 2) ? CMD_NONE : CMD_RESET,
                   (i == 2) ? 8'h00 : 8'h06 + 8'(i), (i == 2), 0);
      tick(2);
      `CHK(cfg_rd, CFG_RST)
    end
    // Launch, watch reference and modulator, then abandon by command
    c = '{3'h0, 1'b0, 2'h3, 1'b0, 1'b0};
    u_host.wr_cfg(c, 0);
    u_host.issue(CMD_LAUNCH, 8'h00, 1'b0, 1);
    tick(1230);
    `CHK(ref_ready, 1'b0)
    tick(40);
    `CHK(ref_ready, 1'b1)
    n = 0;
    repeat (3906) begin
      tick(1);
      if (mod_en === 1'b1)
        n++;
    end
    `CHK((n >= 19 && n <= 21), 1'b1)
    `CHK({busy, analog_on}, 2'b11)
    u_host.issue(CMD_RESET, RST_CODE_B, 1'b0, 0);
    tick(2);
    `CHK({busy, rdy_n, cfg_rd}, {2'b01, CFG_RST})
    // Single shot restarted by a write, with sleep asked mid-way
    c.input_select = 3'($urandom % 3);
    c.gain4 = 1'($urandom);
    u_host.wr_cfg(c, 0);
    u_host.issue(CMD_LAUNCH, 8'h00, 1'b0, 2);
    tick(1000);
    c.input_select = 3'h7;
    u_host.wr_cfg(c, 0);
    t0 = cyc;
    tick(5000);
    u_host.issue(CMD_SLEEP, 8'h00, 1'b0, 0);
    r1 = 24'($urandom);
    filt_q <= r1;
    wait_rdy(1'b0, 60000);
    n = cyc - t0;
    `CHK(in_win(n, 2 * SS_T3), 1'b1)
    `CHK(result, r1)
    tick(2);
    `CHK({busy, analog_on, rdy_n}, 3'b000)
    u_host.issue(CMD_READ, 8'h00, 1'b0, 0);
    wait_rdy(1'b1, 1000);
    `CHK({rdy_n, result}, {1'b1, r1})
    u_host.issue(CMD_READ, 8'h00, 1'b0, 0);
    tick(2);
    `CHK({rdy_n, result}, {1'b1, r1})
    // Continuous, single-ended with a negative filter value
    c = '{3'(3 + $urandom % 4), 1'b0, 2'h3, 1'b1, 1'b0};
    u_host.wr_cfg(c, 1);
    t0 = cyc;
    filt_q <= {1'b1, 23'($urandom)};
    tick(20000);
    `CHK({rdy_n, result}, {1'b1, r1})
    wait_rdy(1'b0, 60000);
    n = cyc - t0;
    `CHK(in_win(n, 2 * CONT_T3 + START_HALF), 1'b1)
    `CHK(result, 24'h000000)
    `CHK(u_host.avg_sub(result, r1, r1), 24'(24'h000000 - r1))
    tick(2);
    `CHK(busy, 1'b1)
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    #1;
    `CHK({busy, cfg_rd}, {1'b0, CFG_RST})
    end_sim();
  end
endmodule
